// *** core/usb_ep_bank_flow.sv ***
// Purpose: Endpoint bank flow, frame timing and event flags of a USB device, behind an APB slave.
// Assumes: Link events arrive as one-cycle pulses on ref_clk; vbus_level is a raw pin.
// Notes: One IN endpoint with two banks and one two-bank OUT occupancy tracker.
//
// What this block does
// RQ1 - Manual mode: empty current IN bank sets tx ready flag, gated to interrupt.
// RQ2 - Software clears tx ready flag before writing bank data through data port.
// RQ3 - Software clears bank control after last byte or when access allowed drops.
// RQ4 - Two banks; on release a free next bank sets tx ready at once.
// RQ5 - Auto switch releases a filled bank itself and ignores bank control clears.
// RQ6 - Under auto switch software writes only while access allowed is set.
// RQ7 - DMA with auto switch frees full banks; software frees a partial bank.
// RQ8 - During DMA auto transfers software leaves data port and byte count alone.
// RQ9 - DMA without auto: clear tx ready, await access drop, clear bank control.
// RQ10 - Host aborts IN with zero length OUT; discard control frees last written bank.
// RQ11 - Iso switching swaps banks on each frame start that finds the current bank not full, and ignores bank control clears.
// RQ12 - A missing frame start is replaced internally, switching banks and counting frames.
// RQ13 - Host IN request on an empty bank sets the underrun flag.
// RQ14 - OUT packet arriving with both OUT banks full is dropped.
// RQ15 - OUT packet with CRC error sets stall flag and received data flag.
// RQ16 - Oversized OUT packet sets overrun, is acknowledged, records the bank size as its byte count.
// RQ17 - Three milliseconds of bus inactivity set the suspend flag.
// RQ18 - Frame start flags set for good frames and for frame number CRC errors.
// RQ19 - Separate flags for bus power change, upstream resume, resume end, wake, reset end.
// RQ20 - Endpoint flags for tx ready, received OUT data and received SETUP.
// RQ21 - Endpoint flags for stall, overrun, underrun, NAK on IN and NAK on OUT.
// RQ22 - Endpoint interrupt follows any enabled flag until software clears it.
`timescale 1ns/100ps
`include "usb_ep_defines.svh"
module usb_ep_bank_flow #(
  parameter int BANK_BYTES = 64,
  parameter int SUSPEND_CYCLES = `SUSPEND_CYCLES,
  parameter int SOF_MISS_CYCLES = `SOF_MISS_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic dma_wr,
  input wire logic [7:0] dma_data,
  input wire logic dma_eot,
  output logic dma_ready,
  input wire logic in_req,
  input wire logic in_rd,
  input wire logic in_done,
  output logic in_ready,
  output logic [7:0] in_rd_data,
  input wire logic nak_in_sent,
  input wire logic nak_out_sent,
  input wire logic out_end,
  input wire logic [10:0] out_len,
  input wire logic out_crc_err,
  input wire logic setup_rx,
  output logic out_ack,
  output logic out_drop,
  input wire logic sof_pulse,
  input wire logic sof_micro,
  input wire logic [10:0] sof_fnum,
  input wire logic sof_crc_err,
  input wire logic bus_active,
  input wire logic vbus_level,
  input wire logic up_resume_sent,
  input wire logic resume_end,
  input wire logic wake_seen,
  input wire logic bus_reset_end,
  output logic endpoint_irq
);
  localparam usb_ep_pkg::count_t BANK_MAX = usb_ep_pkg::count_t'(BANK_BYTES);
  localparam logic [15:0] SOF_LAST = 16'(SOF_MISS_CYCLES - 1);
  localparam logic [16:0] SUSP_LAST = 17'(SUSPEND_CYCLES - 1);

  usb_ep_pkg::top_state_s s_reg;
  usb_ep_pkg::top_state_s s_next;

  logic acc;
  logic wr;
  logic bank_wr;
  logic [7:0] bank_wdata;
  logic bank_release;
  logic bank_kill;
  logic clear_req;
  logic clear_ok;
  logic sof_miss;
  logic cur_free;
  logic bank_ctl;
  logic access_allowed;
  logic access_next;
  usb_ep_pkg::count_t byte_count;
  logic send_ready;
  logic [7:0] ep_set;
  logic [7:0] ep_clr;
  logic [7:0] glb_set;
  logic [7:0] glb_clr;
  logic [1:0] out_inc;
  logic [1:0] out_dec;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a[7:2] == off[7:2]);
  endfunction

  in_bank_store #(.BANK_BYTES(BANK_BYTES)) u_bank (
    .ref_clk(ref_clk),
    .rst(rst),
    .wr_en(bank_wr),
    .wr_data(bank_wdata),
    .release_bank(bank_release),
    .auto_release(s_reg.ctrl[`CTRL_AUTO]),
    .kill_bank(bank_kill),
    .host_rd(in_rd),
    .host_done(in_done),
    .cur_free(cur_free),
    .bank_ctl(bank_ctl),
    .access_allowed(access_allowed),
    .access_next(access_next),
    .byte_count(byte_count),
    .send_ready(send_ready),
    .rd_data(in_rd_data)
  );

  always_comb begin
    s_next = s_reg;
    s_next.pready = 1'b0;
    s_next.pslverr = 1'b0;
    s_next.out_ack = 1'b0;
    s_next.out_drop = 1'b0;
    // The write takes effect on the edge that completes the access phase.
    acc = psel && penable && s_reg.pready;
    wr = acc && pwrite;
    ep_set = 8'h00;
    ep_clr = 8'h00;
    glb_set = 8'h00;
    glb_clr = 8'h00;
    out_inc = 2'h0;
    out_dec = 2'h0;
    sof_miss = 1'b0;

    if (s_reg.ctrl[`CTRL_DMA]) begin
      bank_wr = dma_wr;
      bank_wdata = dma_data;
    end else begin
      bank_wr = wr && hit(paddr, `REG_DATA);
      bank_wdata = pwdata[7:0];
    end

    // Bank control clears count only in manual mode, or after the DMA ended on a partial bank.
    clear_req = wr && hit(paddr, `REG_EP_STAT) && !pwdata[`EPS_BANK_CTL] && bank_ctl;
    clear_ok = clear_req && (!(s_reg.ctrl[`CTRL_AUTO] || s_reg.ctrl[`CTRL_ISO]) || s_reg.eot_seen); // RQ5 RQ7 RQ11
    bank_kill = wr && hit(paddr, `REG_EP_STAT) && pwdata[`EPS_DISCARD]; // RQ10
    if (dma_eot && s_reg.ctrl[`CTRL_DMA]) begin
      s_next.eot_seen = 1'b1;
    end else if (clear_ok) begin
      s_next.eot_seen = 1'b0;
    end

    // Frame timing: a real frame start reloads the watchdog, a silent one is substituted.
    if (sof_pulse) begin
      s_next.sof_cnt = 16'h0000;
      s_next.sof_seen = 1'b1;
      s_next.fnum_crc = sof_crc_err;
      s_next.frame_number = sof_crc_err ? s_reg.frame_number + 11'h001 : sof_fnum;
      glb_set[sof_micro ? `GF_MICROFRAME : `GF_FRAME] = 1'b1; // RQ18
    end else if (s_reg.sof_seen && !s_reg.suspended) begin
      if (s_reg.sof_cnt == SOF_LAST) begin
        sof_miss = 1'b1; // RQ12
        s_next.sof_cnt = 16'h0000;
        s_next.frame_number = s_reg.frame_number + 11'h001; // RQ12
        glb_set[`GF_FRAME] = 1'b1; // RQ12
      end else begin
        s_next.sof_cnt = s_reg.sof_cnt + 16'h0001;
      end
    end
    if (bus_reset_end) begin
      s_next.sof_seen = 1'b0;
    end
    bank_release = clear_ok || (s_reg.ctrl[`CTRL_ISO] && (sof_pulse || sof_miss)); // RQ3 RQ9 RQ11 RQ12

    // Suspend after a long idle bus; any activity restarts the count.
    if (bus_active) begin
      s_next.idle_cnt = 17'h00000;
      s_next.suspended = 1'b0;
    end else if (!s_reg.suspended) begin
      if (s_reg.idle_cnt == SUSP_LAST) begin
        s_next.suspended = 1'b1;
        glb_set[`GF_SUSPEND] = 1'b1; // RQ17
      end else begin
        s_next.idle_cnt = s_reg.idle_cnt + 17'h00001;
      end
    end

    // The power pin is raw, so the change detector compares the second stage with its delayed copy and never uses the first.
    s_next.vbus_s1 = vbus_level;
    s_next.vbus_s2 = s_reg.vbus_s1;
    s_next.vbus_d = s_reg.vbus_s2;
    glb_set[`GF_BUS_POWER] = s_reg.vbus_s2 ^ s_reg.vbus_d; // RQ19
    glb_set[`GF_UP_RESUME] = up_resume_sent; // RQ19
    glb_set[`GF_RESUME_END] = resume_end; // RQ19
    glb_set[`GF_WAKE] = wake_seen; // RQ19
    glb_set[`GF_RESET_END] = bus_reset_end; // RQ19

    // IN side: the flag rises whenever the current bank turns free, also right after a release.
    s_next.cur_free_d = cur_free;
    ep_set[`EPF_TX_READY] = cur_free && !s_reg.cur_free_d; // RQ1 RQ4 RQ20
    ep_set[`EPF_UNDERRUN] = in_req && !send_ready; // RQ13 RQ21
    ep_set[`EPF_NAK_IN] = nak_in_sent; // RQ21
    ep_set[`EPF_NAK_OUT] = nak_out_sent; // RQ21
    ep_set[`EPF_SETUP_RX] = setup_rx; // RQ20

    // OUT side: a packet with no free bank is lost, otherwise it is always acknowledged.
    if (out_end) begin
      if (s_reg.out_occ == 2'h2) begin
        s_next.out_drop = 1'b1; // RQ14
      end else begin
        out_inc = 2'h1;
        s_next.out_ack = 1'b1; // RQ16
        ep_set[`EPF_RX_DATA] = 1'b1; // RQ15 RQ16 RQ20
        ep_set[`EPF_STALL] = out_crc_err; // RQ15 RQ21
        ep_set[`EPF_OVERRUN] = out_len > 11'(BANK_BYTES); // RQ16 RQ21
        s_next.out_cnt = (out_len > 11'(BANK_BYTES)) ? BANK_MAX : out_len[7:0]; // RQ16
      end
    end
    if (wr && hit(paddr, `REG_EP_STAT) && pwdata[`EPS_OUT_FREE] && s_reg.out_occ != 2'h0) begin
      out_dec = 2'h1;
    end
    s_next.out_occ = s_reg.out_occ + out_inc - out_dec;

    // Flags clear by writing zero; a set in the same cycle wins.
    if (wr && hit(paddr, `REG_EP_STAT)) begin
      ep_clr = ~pwdata[7:0];
    end
    if (wr && hit(paddr, `REG_GLB_STAT)) begin
      glb_clr = ~pwdata[7:0];
    end
    s_next.ep_flags = (s_reg.ep_flags & ~ep_clr) | ep_set;
    s_next.glb_flags = (s_reg.glb_flags & ~glb_clr) | glb_set;
    if (wr && hit(paddr, `REG_CTRL)) begin
      s_next.ctrl = pwdata[2:0];
    end
    if (wr && hit(paddr, `REG_EP_EN)) begin
      s_next.ep_en = pwdata[7:0];
    end
    s_next.irq = |(s_next.ep_flags & s_next.ep_en); // RQ1 RQ22
    s_next.in_ready = send_ready;
    s_next.dma_ready = s_next.ctrl[`CTRL_DMA] && access_next;

    // One wait state: read data is latched together with pready.
    if (psel && penable && !s_reg.pready) begin
      s_next.pready = 1'b1;
      s_next.prdata = 32'h00000000;
      unique case (paddr[7:2])
        6'h00: s_next.prdata = {29'h00000000, s_reg.ctrl};
        6'h01: s_next.prdata = {22'h000000, access_allowed, bank_ctl, s_reg.ep_flags};
        6'h02: s_next.prdata = {24'h000000, s_reg.ep_en};
        6'h03: s_next.prdata = 32'h00000000;
        6'h04: s_next.prdata = {24'h000000, byte_count};
        6'h05: s_next.prdata = {23'h000000, s_reg.fnum_crc, s_reg.glb_flags};
        6'h06: s_next.prdata = {13'h0000, s_reg.out_cnt, s_reg.frame_number};
        default: s_next.pslverr = 1'b1;
      endcase
    end else if (acc) begin
      s_next.prdata = s_reg.prdata;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_reg <= '0;
      s_reg.ctrl <= `CTRL_RST;
      s_reg.ep_en <= `EP_EN_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign prdata = s_reg.prdata;
  assign pready = s_reg.pready;
  assign pslverr = s_reg.pslverr;
  assign dma_ready = s_reg.dma_ready;
  assign in_ready = s_reg.in_ready;
  assign out_ack = s_reg.out_ack;
  assign out_drop = s_reg.out_drop;
  assign endpoint_irq = s_reg.irq;
endmodule // usb_ep_bank_flow

// *** core/usb_ep_defines.svh ***
// Purpose: Offsets, field positions, reset values and timing counts of the endpoint bank block.
// Assumes: 20 MHz ref_clk; APB byte addresses, one 32-bit word per register.
// Notes: Definitions only.
`ifndef USB_EP_DEFINES_SVH
`define USB_EP_DEFINES_SVH

`define REG_CTRL 8'h00
`define REG_EP_STAT 8'h04
`define REG_EP_EN 8'h08
`define REG_DATA 8'h0C
`define REG_BYTE_COUNT 8'h10
`define REG_GLB_STAT 8'h14
`define REG_FRAME 8'h18

`define CTRL_AUTO 0
`define CTRL_DMA 1
`define CTRL_ISO 2
`define CTRL_RST 3'h0

`define EPF_TX_READY 0
`define EPF_RX_DATA 1
`define EPF_SETUP_RX 2
`define EPF_STALL 3
`define EPF_OVERRUN 4
`define EPF_UNDERRUN 5
`define EPF_NAK_IN 6
`define EPF_NAK_OUT 7
`define EPS_BANK_CTL 8
`define EPS_ACCESS 9
`define EPS_DISCARD 10
`define EPS_OUT_FREE 11
`define EP_EN_RST 8'h00

`define GF_SUSPEND 0
`define GF_MICROFRAME 1
`define GF_FRAME 2
`define GF_RESET_END 3
`define GF_WAKE 4
`define GF_RESUME_END 5
`define GF_UP_RESUME 6
`define GF_BUS_POWER 7
`define GS_FNUM_CRC 8

`define CLK_HZ 20000000
`define SUSPEND_TIME_US 3000
`define SOF_MISS_TIME_US 1010
`define SUSPEND_CYCLES (`SUSPEND_TIME_US * (`CLK_HZ / 1000000))
`define SOF_MISS_CYCLES (`SOF_MISS_TIME_US * (`CLK_HZ / 1000000))

`endif

// *** core/usb_ep_pkg.sv ***
// Purpose: State types of the endpoint bank block.
// Assumes: Banks of at most 255 bytes, timing counts below 65536 and 131072.
// Notes: Each module keeps its state in one of these structs, apart from the bank byte memory of in_bank_store.
package usb_ep_pkg;

  typedef logic [7:0] count_t;

  typedef struct packed {
    logic [1:0] full;
    logic [1:0][7:0] cnt;
    logic wptr;
    logic rptr;
    count_t rd_idx;
    logic [7:0] rd_data;
  } bank_state_s;

  typedef struct packed {
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
    logic [2:0] ctrl;
    logic [7:0] ep_flags;
    logic [7:0] ep_en;
    logic [7:0] glb_flags;
    logic fnum_crc;
    logic [10:0] frame_number;
    logic [1:0] out_occ;
    count_t out_cnt;
    logic sof_seen;
    logic [15:0] sof_cnt;
    logic [16:0] idle_cnt;
    logic suspended;
    logic vbus_s1;
    logic vbus_s2;
    logic vbus_d;
    logic cur_free_d;
    logic eot_seen;
    logic irq;
    logic in_ready;
    logic dma_ready;
    logic out_ack;
    logic out_drop;
  } top_state_s;

endpackage

// *** core/in_bank_store.sv ***
// Purpose: Two IN banks with byte storage, fill and send pointers.
// Assumes: Writes beyond a full bank are ignored.
// Notes: A kill frees the most recently released bank still waiting to go out.
`timescale 1ns/100ps
module in_bank_store #(
  parameter int BANK_BYTES = 64
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  input wire logic release_bank,
  input wire logic auto_release,
  input wire logic kill_bank,
  input wire logic host_rd,
  input wire logic host_done,
  output logic cur_free,
  output logic bank_ctl,
  output logic access_allowed,
  output logic access_next,
  output usb_ep_pkg::count_t byte_count,
  output logic send_ready,
  output logic [7:0] rd_data
);
  localparam usb_ep_pkg::count_t BANK_MAX = usb_ep_pkg::count_t'(BANK_BYTES);

  usb_ep_pkg::bank_state_s s_reg;
  usb_ep_pkg::bank_state_s s_next;
  logic [7:0] mem [0:2*BANK_BYTES-1];
  logic do_wr;
  int waddr;
  int raddr;

  always_comb begin
    s_next = s_reg;
    do_wr = wr_en && !s_reg.full[s_reg.wptr] && (s_reg.cnt[s_reg.wptr] < BANK_MAX);
    waddr = (s_reg.wptr ? BANK_BYTES : 0) + int'(s_reg.cnt[s_reg.wptr]);
    raddr = (s_reg.rptr ? BANK_BYTES : 0) + int'(s_reg.rd_idx);
    if (do_wr) begin
      s_next.cnt[s_reg.wptr] = s_reg.cnt[s_reg.wptr] + 8'h01;
    end
    // A bank is released by software, by a frame start, or by itself once full.
    if (!s_reg.full[s_reg.wptr] && (release_bank || (auto_release && s_next.cnt[s_reg.wptr] == BANK_MAX))) begin // RQ5 RQ7
      s_next.full[s_reg.wptr] = 1'b1;
      s_next.wptr = ~s_reg.wptr;
    end
    if (host_rd && s_reg.full[s_reg.rptr]) begin
      s_next.rd_data = mem[raddr];
      s_next.rd_idx = s_reg.rd_idx + 8'h01;
    end
    if (host_done && s_reg.full[s_reg.rptr]) begin
      s_next.full[s_reg.rptr] = 1'b0;
      s_next.cnt[s_reg.rptr] = 8'h00;
      s_next.rd_idx = 8'h00;
      s_next.rptr = ~s_reg.rptr;
    end
    if (kill_bank && s_reg.full[~s_reg.wptr]) begin // RQ10
      s_next.full[~s_reg.wptr] = 1'b0;
      s_next.cnt[~s_reg.wptr] = 8'h00;
      // Sending resumes at the older full bank, or else at the bank now being filled.
      if (s_reg.rptr != s_reg.wptr) begin
        s_next.rd_idx = 8'h00;
      end
      s_next.rptr = s_reg.wptr;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (do_wr) begin
      mem[waddr] <= wr_data;
    end
  end

  assign cur_free = !s_reg.full[s_reg.wptr] && s_reg.cnt[s_reg.wptr] == 8'h00;
  assign bank_ctl = !s_reg.full[s_reg.wptr];
  assign access_allowed = !s_reg.full[s_reg.wptr] && s_reg.cnt[s_reg.wptr] < BANK_MAX;
  assign access_next = !s_next.full[s_next.wptr] && s_next.cnt[s_next.wptr] < BANK_MAX;
  assign byte_count = s_reg.cnt[s_reg.wptr];
  assign send_ready = s_reg.full[s_reg.rptr];
  assign rd_data = s_reg.rd_data;
endmodule // in_bank_store

// *** bench/usb_ep_bank_flow_asserts.sv ***
// Purpose: Port checks of the endpoint bank block.
// Assumes: One ref_clk domain, synchronous active-high rst.
// Notes: Bound to every usb_ep_bank_flow instance.
`timescale 1ns/100ps
module usb_ep_bank_flow_asserts (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic out_end,
  input wire logic out_ack,
  input wire logic out_drop,
  input wire logic endpoint_irq
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  property p_wait; psel && penable && !pready |=> pready; endproperty
  a_wait: assert property (p_wait) else $error("pready late");
  property p_idle; !(psel && penable) |=> !pready; endproperty
  a_idle: assert property (p_idle) else $error("pready without access");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("pready too long");
  property p_map; pready |-> (pslverr == (paddr > 8'h18)); endproperty
  a_map: assert property (p_map) else $error("pslverr wrong");
  property p_err_only; pslverr |-> pready && prdata == 32'h0; endproperty
  a_err_only: assert property (p_err_only) else $error("pslverr stray");
  property p_out_resp; out_end |=> (out_ack != out_drop); endproperty
  a_out_resp: assert property (p_out_resp) else $error("OUT answer wrong");
  property p_resp_cause; (out_ack || out_drop) |-> $past(out_end); endproperty
  a_resp_cause: assert property (p_resp_cause) else $error("OUT answer stray");
  property p_rst_quiet; $fell(rst) |-> !pready && !endpoint_irq && !out_ack; endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("output busy in reset");
  c_drop: cover property (out_drop);
  c_err: cover property (pready && pslverr);
  c_irq: cover property ($rose(endpoint_irq));
endmodule // usb_ep_bank_flow_asserts

bind usb_ep_bank_flow usb_ep_bank_flow_asserts i_chk (.ref_clk, .rst, .psel, .penable, .paddr, .prdata, .pready,
  .pslverr, .out_end, .out_ack, .out_drop, .endpoint_irq);

// *** bench/usb_host_model.sv ***
// Purpose: Behavioural USB host issuing IN, OUT and frame start traffic.
// Assumes: Each task starts at a rising ref_clk edge.
// Notes: Released data lines carry the inverse of their last value, so stale data cannot pass.
`timescale 1ns/100ps
module usb_host_model (
  input wire logic ref_clk,
  input wire logic [7:0] in_rd_data,
  input wire logic out_ack,
  input wire logic out_drop,
  output logic in_req,
  output logic in_rd,
  output logic in_done,
  output logic out_end,
  output logic [10:0] out_len,
  output logic out_crc_err,
  output logic sof_pulse,
  output logic sof_micro,
  output logic [10:0] sof_fnum,
  output logic sof_crc_err,
  output logic bus_active
);
  logic [7:0] got [0:7];
  logic ack, drop;
  initial begin
    {in_req, in_rd, in_done, out_end, out_crc_err, sof_pulse, sof_micro, sof_crc_err} = 8'h0;
    out_len = 11'h0;
    sof_fnum = 11'h0;
    bus_active = 1'h1;
  end
  task automatic in_xfer(input int n);
    @(posedge ref_clk);
    in_req <= 1'h1;
    for (int k = 0; k < n; k++) begin
      @(posedge ref_clk);
      in_req <= 1'h0;
      in_rd <= 1'h1;
      @(posedge ref_clk);
      in_rd <= 1'h0;
      @(posedge ref_clk);
      got[k] = in_rd_data;
    end
    in_done <= 1'h1;
    @(posedge ref_clk);
    in_done <= 1'h0;
  endtask
  // A token with nothing offered probes the empty-bank case.
  task automatic in_token;
    @(posedge ref_clk);
    in_req <= 1'h1;
    @(posedge ref_clk);
    in_req <= 1'h0;
  endtask
  task automatic out_pkt(input logic [10:0] len, input logic crc);
    @(posedge ref_clk);
    {out_end, out_len, out_crc_err} <= {1'h1, len, crc};
    @(posedge ref_clk);
    {out_end, out_len, out_crc_err} <= {1'h0, ~len, ~crc};
    @(posedge ref_clk);
    ack = out_ack;
    drop = out_drop;
  endtask
  task automatic sof(input logic [10:0] f, input logic m, input logic c);
    @(posedge ref_clk);
    {sof_pulse, sof_fnum, sof_micro, sof_crc_err} <= {1'h1, f, m, c};
    @(posedge ref_clk);
    {sof_pulse, sof_fnum, sof_micro, sof_crc_err} <= {1'h0, ~f, ~m, ~c};
  endtask
  task automatic idle(input int n);
    @(posedge ref_clk);
    bus_active <= 1'h0;
    repeat (n) @(posedge ref_clk);
    bus_active <= 1'h1;
  endtask
endmodule // usb_host_model

// *** bench/usb_ep_bank_flow_tb_top.sv ***
// Purpose: Self-checking bench of the endpoint bank block.
// Assumes: Four-byte banks and short frame and suspend counts keep the run brief.
// Notes: The host side is played by usb_host_model.
`timescale 1ns/100ps
`include "usb_ep_defines.svh"
module usb_ep_bank_flow_tb_top;
  logic ref_clk, rst, psel, penable, pwrite, pready, pslverr, serr, dma_wr, dma_eot, dma_ready, vbus_level;
  logic in_req, in_rd, in_done, in_ready, out_end, out_crc_err, out_ack, out_drop, endpoint_irq;
  logic sof_pulse, sof_micro, sof_crc_err, bus_active;
  logic [7:0] paddr, dma_data, in_rd_data;
  logic [10:0] out_len, sof_fnum;
  logic [31:0] pwdata, prdata, rd;
  logic [6:0] ev;
  int failures = 0;
  int checks = 0;
  int pos [7] = '{`EPF_SETUP_RX, `EPF_NAK_IN, `EPF_NAK_OUT, `GF_UP_RESUME, `GF_RESUME_END, `GF_WAKE, `GF_RESET_END};
  usb_ep_bank_flow #(.BANK_BYTES(4), .SUSPEND_CYCLES(50), .SOF_MISS_CYCLES(30)) i_dut (.ref_clk, .rst, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .dma_wr, .dma_data, .dma_eot, .dma_ready,
    .in_req, .in_rd, .in_done, .in_ready, .in_rd_data, .nak_in_sent(ev[1]), .nak_out_sent(ev[2]), .out_end,
    .out_len, .out_crc_err, .setup_rx(ev[0]), .out_ack, .out_drop, .sof_pulse, .sof_micro, .sof_fnum,
    .sof_crc_err, .bus_active, .vbus_level, .up_resume_sent(ev[3]), .resume_end(ev[4]), .wake_seen(ev[5]),
    .bus_reset_end(ev[6]), .endpoint_irq);
  usb_host_model i_host (.ref_clk, .in_rd_data, .out_ack, .out_drop, .in_req, .in_rd, .in_done, .out_end,
    .out_len, .out_crc_err, .sof_pulse, .sof_micro, .sof_fnum, .sof_crc_err, .bus_active);
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    {psel, pwrite, paddr, pwdata} <= {1'h1, w, a, d};
    @(posedge ref_clk);
    penable <= 1'h1;
    // Only the watchdog ends a wait for pready.
    do begin
      @(posedge ref_clk);
    end while (pready !== 1'h1);
    rd = prdata;
    serr = pslverr;
    {psel, penable} <= 2'h0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask
  task automatic get(input logic [7:0] a);
    apb(1'h0, a, 32'h0);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic fill(input int n, input logic [7:0] b);
    for (int k = 0; k < n; k++) wr(`REG_DATA, b + k);
  endtask
  task automatic host_read(input int n, input logic [7:0] b);
    i_host.in_xfer(n);
    for (int k = 0; k < n; k++) chk(i_host.got[k], b + k);
  endtask
  task automatic dma_push(input int n, input logic [7:0] b);
    for (int k = 0; k < n; k++) begin
      @(posedge ref_clk);
      {dma_wr, dma_data} <= {1'h1, b + k[7:0]};
      @(posedge ref_clk);
      dma_wr <= 1'h0;
    end
  endtask
  task automatic out_chk(input logic [10:0] len, input logic crc, input logic [1:0] e);
    i_host.out_pkt(len, crc);
    chk({i_host.ack, i_host.drop}, e);
  endtask
  task automatic t_manual;
    get(8'h1C);
    chk(serr, 1'h1);
    chk(rd, 32'h0);
    wr(`REG_EP_EN, 32'h1);
    tick(3);
    chk(endpoint_irq, 1'h1);
    wr(`REG_EP_STAT, 32'h1FE);
    tick(3);
    chk(endpoint_irq, 1'h0);
    fill(4, 8'hA0);
    get(`REG_BYTE_COUNT);
    chk(rd, 32'h4);
    get(`REG_EP_STAT);
    chk(rd[`EPS_ACCESS], 1'h0);
    wr(`REG_EP_STAT, 32'h0FF);
    tick(3);
    chk(in_ready, 1'h1);
    get(`REG_EP_STAT);
    chk(rd[`EPF_TX_READY], 1'h1);
    host_read(4, 8'hA0);
    i_host.in_token();
    get(`REG_EP_STAT);
    chk(rd[`EPF_UNDERRUN], 1'h1);
    wr(`REG_EP_EN, 32'h0);
  endtask
  task automatic t_auto_dma;
    wr(`REG_CTRL, 32'h1);
    fill(4, 8'hB0);
    tick(3);
    chk(in_ready, 1'h1);
    host_read(4, 8'hB0);
    wr(`REG_EP_STAT, 32'h0);
    tick(3);
    chk(in_ready, 1'h0);
    wr(`REG_CTRL, 32'h3);
    tick(1);
    chk(dma_ready, 1'h1);
    dma_push(4, 8'hC0);
    tick(3);
    chk(in_ready, 1'h1);
    host_read(4, 8'hC0);
    dma_push(1, 8'hD0);
    dma_eot <= 1'h1;
    tick(1);
    dma_eot <= 1'h0;
    wr(`REG_EP_STAT, 32'h0);
    tick(3);
    chk(in_ready, 1'h1);
    host_read(1, 8'hD0);
    wr(`REG_CTRL, 32'h2);
    dma_push(4, 8'hF0);
    tick(3);
    chk(in_ready, 1'h0);
    get(`REG_EP_STAT);
    chk(rd[`EPS_ACCESS], 1'h0);
    wr(`REG_EP_STAT, 32'h0FF);
    tick(3);
    chk(in_ready, 1'h1);
    wr(`REG_EP_STAT, 32'h5FF);
    tick(3);
    chk(in_ready, 1'h0);
    dma_push(1, 8'hF8);
    wr(`REG_EP_STAT, 32'h0FF);
    tick(3);
    chk(in_ready, 1'h1);
    host_read(1, 8'hF8);
  endtask
  task automatic t_out;
    wr(`REG_EP_STAT, 32'h100);
    out_chk(11'h2, 1'h0, 2'h2);
    out_chk(11'h9, 1'h0, 2'h2);
    get(`REG_FRAME);
    chk(rd[18:11], 8'h4);
    get(`REG_EP_STAT);
    chk({rd[`EPF_OVERRUN], rd[`EPF_RX_DATA]}, 2'h3);
    out_chk(11'h1, 1'h0, 2'h1);
    wr(`REG_EP_STAT, 32'h900);
    out_chk(11'h3, 1'h1, 2'h2);
    get(`REG_EP_STAT);
    chk({rd[`EPF_STALL], rd[`EPF_RX_DATA]}, 2'h3);
  endtask
  task automatic t_frames;
    wr(`REG_CTRL, 32'h4);
    fill(2, 8'hE0);
    i_host.sof(11'h5, 1'h0, 1'h0);
    tick(3);
    chk(in_ready, 1'h1);
    get(`REG_GLB_STAT);
    chk(rd[`GF_FRAME], 1'h1);
    i_host.sof(11'h5, 1'h1, 1'h1);
    get(`REG_GLB_STAT);
    chk({rd[`GS_FNUM_CRC], rd[`GF_MICROFRAME]}, 2'h3);
    get(`REG_FRAME);
    chk(rd[10:0], 11'h6);
    tick(24);
    get(`REG_FRAME);
    chk(rd[10:0], 11'h7);
  endtask
  task automatic t_events;
    wr(`REG_CTRL, 32'h0);
    i_host.idle(60);
    get(`REG_GLB_STAT);
    chk(rd[`GF_SUSPEND], 1'h1);
    for (int i = 0; i < 7; i++) begin
      ev <= 7'h1 << i;
      tick(1);
      ev <= 7'h0;
      get(i < 3 ? `REG_EP_STAT : `REG_GLB_STAT);
      chk(rd[pos[i]], 1'h1);
    end
    vbus_level <= 1'h1;
    tick(5);
    get(`REG_GLB_STAT);
    chk(rd[`GF_BUS_POWER], 1'h1);
  endtask
  initial begin
    ref_clk = 1'h0;
    forever #25 ref_clk = ~ref_clk;
  end
  initial begin
    rst = 1'h1;
    {psel, penable, pwrite, dma_wr, dma_eot, vbus_level, ev} = 13'h0;
    {paddr, pwdata, dma_data} = 48'h0;
    repeat (8) @(posedge ref_clk);
    rst <= 1'h0;
    t_manual();
    t_auto_dma();
    t_out();
    t_frames();
    t_events();
    give_verdict();
  end
  initial begin
    #2000000;
    failures++;
    give_verdict();
  end
endmodule // usb_ep_bank_flow_tb_top
